//--- pkpc_pkg.sv
// shared constants and types for the pad keeper and power-down control block
package pkpc_pkg;

  // keeper selection codes, one field per pin
  localparam int KEEP_W = 2;
  localparam logic [KEEP_W-1:0] KEEP_NONE = 2'h0;
  localparam logic [KEEP_W-1:0] KEEP_UP = 2'h1;
  localparam logic [KEEP_W-1:0] KEEP_DOWN = 2'h2;
  localparam logic [KEEP_W-1:0] KEEP_FOLLOW = 2'h3;

  // decoded keeper bits {pull_up, pull_down, follow}
  localparam int KD_UP = 2;
  localparam int KD_DOWN = 1;
  localparam int KD_FOLLOW = 0;

  // drive setting: low selects the 4 mA sink setting
  localparam logic DRIVE_4MA = 1'h0;
  localparam logic DRIVE_16MA = 1'h1;

  // unconfigured pad defaults
  localparam logic HYST_DEFAULT = 1'h1;
  localparam logic CLAMP_DEFAULT = 1'h0;
  localparam logic CORE_IN_FORCED = 1'h1;

  // boundary-scan cells per pin and their place in the group
  localparam int BS_CELLS = 3;
  localparam int BS_IN_POS = 0;
  localparam int BS_OUT_POS = 1;
  localparam int BS_OE_POS = 2;

  localparam int DEFAULT_PINS = 8;

  typedef enum logic [1:0] {PH_CFG, PH_RUN, PH_PD} pkpc_phase_t;

endpackage

//--- pkpc_bscan_chain.sv
// boundary-scan capture, shift and update register chain
`timescale 1ns/100ps
module pkpc_bscan_chain #(
  parameter int W = pkpc_pkg::BS_CELLS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // parallel side
  input wire logic [W-1:0] cap_vec,
  output logic [W-1:0] upd_vec,
  // serial test side
  input wire logic bs_tdi,
  input wire logic bs_capture,
  input wire logic bs_shift,
  input wire logic bs_update,
  output logic bs_tdo
);

  logic [W-1:0] shift_r;
  logic [W-1:0] shift_nxt;
  logic [W-1:0] upd_r;
  logic [W-1:0] upd_nxt;

  always_comb
  begin
    shift_nxt = shift_r;
    upd_nxt = upd_r;
    if (bs_capture)
    begin
      shift_nxt = cap_vec;
    end
    else if (bs_shift)
    begin
      shift_nxt = {bs_tdi, shift_r[W-1:1]};
    end
    // update register keeps the pad stable while the chain shifts
    if (bs_update)
    begin
      upd_nxt = shift_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_r <= '0;
      upd_r <= '0;
    end
    else if (clk_en)
    begin
      shift_r <= shift_nxt;
      upd_r <= upd_nxt;
    end
  end

  assign upd_vec = upd_r;
  assign bs_tdo = shift_r[0];

endmodule

//--- pkpc_pad_ctrl.sv
// per-pin pad keeper, configuration-state and power-down control
`timescale 1ns/100ps
// Operation
// - each pad offers a keeper: pull up, pull down or last-value follower
// - while initializing, every pad keeps its pull-up on
// - supply clamp held off throughout configuration
// - during configuration driver and receiver off, internal input reads high
// - before configuration: scan access only, hysteresis on, 4 mA, pull-up, clamp off
// - after configuration unused pads are inputs with pull-up on, except low-power pads in power-down
// - per-pin choice: low-power in power-down or stay fully active
// - low-power pad in power-down forces driver to high impedance
// - low-power pad in power-down switches keeper to follower
// - per-pin option forces internal input high for low-power pads in power-down
// - boundary-scan cells attached to pads for chip and board test
// - otherwise output enable low floats pin, high drives output value
module pkpc_pad_ctrl #(
  parameter int N = pkpc_pkg::DEFAULT_PINS
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // chip state from configuration and power-down control
  input wire logic cfg_busy,
  input wire logic pd_active,
  input wire logic pad_lowpower_allow,
  // per-pin configuration
  input wire logic [N-1:0] pin_used,
  input wire logic [N*pkpc_pkg::KEEP_W-1:0] keeper_cfg,
  input wire logic [N-1:0] lp_en,
  input wire logic [N-1:0] lp_in_force_hi,
  input wire logic [N-1:0] hyst_cfg,
  input wire logic [N-1:0] drive_cfg,
  input wire logic [N-1:0] clamp_cfg,
  // core side
  input wire logic [N-1:0] core_out,
  input wire logic [N-1:0] core_oe,
  output logic [N-1:0] core_in,
  // pad cell side
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  output logic [N-1:0] pad_pull_up,
  output logic [N-1:0] pad_pull_down,
  output logic [N-1:0] pad_follow,
  output logic [N-1:0] pad_keep_val,
  output logic [N-1:0] pad_rx_en,
  output logic [N-1:0] pad_clamp_en,
  output logic [N-1:0] pad_hyst,
  output logic [N-1:0] pad_drive,
  // boundary scan, from the test controller on this clock
  input wire logic bs_tdi,
  input wire logic bs_capture,
  input wire logic bs_shift,
  input wire logic bs_update,
  input wire logic bs_extest,
  output logic bs_tdo
);

  localparam int BW = N * pkpc_pkg::BS_CELLS;

  function automatic logic [2:0] keep_decode(input logic [pkpc_pkg::KEEP_W-1:0] code);
    logic [2:0] k;
    k = '0;
    case (code)
      pkpc_pkg::KEEP_UP: k[pkpc_pkg::KD_UP] = 1'h1;
      pkpc_pkg::KEEP_DOWN: k[pkpc_pkg::KD_DOWN] = 1'h1;
      pkpc_pkg::KEEP_FOLLOW: k[pkpc_pkg::KD_FOLLOW] = 1'h1;
      default: k = '0;
    endcase
    return k;
  endfunction

  pkpc_pkg::pkpc_phase_t phase_r;
  pkpc_pkg::pkpc_phase_t phase_nxt;
  logic [N-1:0] pin_meta_r;
  logic [N-1:0] pin_sync_r;
  logic [N-1:0] core_in_r, core_in_nxt;
  logic [N-1:0] out_r, out_nxt;
  logic [N-1:0] oe_r, oe_nxt;
  logic [N-1:0] pu_r, pu_nxt;
  logic [N-1:0] pdn_r, pdn_nxt;
  logic [N-1:0] fol_r, fol_nxt;
  logic [N-1:0] keep_r, keep_nxt;
  logic [N-1:0] rx_r, rx_nxt;
  logic [N-1:0] clamp_r, clamp_nxt;
  logic [N-1:0] hyst_r, hyst_nxt;
  logic [N-1:0] drive_r, drive_nxt;
  logic [BW-1:0] bs_cap;
  logic [BW-1:0] bs_upd;

  // phase: configuration, running, power-down
  always_comb
  begin
    phase_nxt = phase_r;
    if (cfg_busy)
    begin
      phase_nxt = pkpc_pkg::PH_CFG;
    end
    else
    begin
      case (phase_r)
        pkpc_pkg::PH_CFG: phase_nxt = pkpc_pkg::PH_RUN;
        // without the permission the pads stay fully active in power-down
        pkpc_pkg::PH_RUN: if (pd_active && pad_lowpower_allow) phase_nxt = pkpc_pkg::PH_PD;
        pkpc_pkg::PH_PD: if (!pd_active) phase_nxt = pkpc_pkg::PH_RUN;
        default: phase_nxt = pkpc_pkg::PH_CFG;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_r <= pkpc_pkg::PH_CFG;
    end
    else if (clk_en)
    begin
      phase_r <= phase_nxt;
    end
  end

  // pin level synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else if (clk_en)
    begin
      pin_meta_r <= pad_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // per-pin pad controls
  always_comb
  begin
    logic [2:0] kd;
    logic lp;
    kd = '0;
    lp = 1'h0;
    for (int i = 0; i < N; i++)
    begin
      kd = keep_decode(keeper_cfg[i*pkpc_pkg::KEEP_W +: pkpc_pkg::KEEP_W]);
      lp = (phase_r == pkpc_pkg::PH_PD) && lp_en[i];
      out_nxt[i] = core_out[i];
      oe_nxt[i] = core_oe[i] & pin_used[i];
      rx_nxt[i] = 1'h1;
      core_in_nxt[i] = pin_sync_r[i];
      hyst_nxt[i] = hyst_cfg[i];
      drive_nxt[i] = drive_cfg[i];
      clamp_nxt[i] = clamp_cfg[i];
      pu_nxt[i] = kd[pkpc_pkg::KD_UP];
      pdn_nxt[i] = kd[pkpc_pkg::KD_DOWN];
      fol_nxt[i] = kd[pkpc_pkg::KD_FOLLOW];
      if (!pin_used[i])
      begin
        pu_nxt[i] = 1'h1;
        pdn_nxt[i] = 1'h0;
        fol_nxt[i] = 1'h0;
      end
      if (phase_r == pkpc_pkg::PH_CFG)
      begin
        oe_nxt[i] = 1'h0;
        rx_nxt[i] = 1'h0;
        core_in_nxt[i] = pkpc_pkg::CORE_IN_FORCED;
        pu_nxt[i] = 1'h1;
        pdn_nxt[i] = 1'h0;
        fol_nxt[i] = 1'h0;
        hyst_nxt[i] = pkpc_pkg::HYST_DEFAULT;
        drive_nxt[i] = pkpc_pkg::DRIVE_4MA;
        clamp_nxt[i] = pkpc_pkg::CLAMP_DEFAULT;
      end
      if (lp)
      begin
        oe_nxt[i] = 1'h0;
        pu_nxt[i] = 1'h0;
        pdn_nxt[i] = 1'h0;
        fol_nxt[i] = 1'h1;
        if (lp_in_force_hi[i])
        begin
          core_in_nxt[i] = pkpc_pkg::CORE_IN_FORCED;
        end
      end
      // scan drive overrides output value and output enable in every phase, also the only path before configuration
      if (bs_extest)
      begin
        out_nxt[i] = bs_upd[i*pkpc_pkg::BS_CELLS + pkpc_pkg::BS_OUT_POS];
        oe_nxt[i] = bs_upd[i*pkpc_pkg::BS_CELLS + pkpc_pkg::BS_OE_POS];
      end
      // follower can only see the pin while someone can observe or drive it
      keep_nxt[i] = (rx_r[i] | oe_r[i]) ? pin_sync_r[i] : keep_r[i];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_r <= '0;
      oe_r <= '0;
      rx_r <= '0;
      core_in_r <= '1;
      pu_r <= '1;
      pdn_r <= '0;
      fol_r <= '0;
      keep_r <= '1;
      hyst_r <= {N{pkpc_pkg::HYST_DEFAULT}};
      drive_r <= {N{pkpc_pkg::DRIVE_4MA}};
      clamp_r <= {N{pkpc_pkg::CLAMP_DEFAULT}};
    end
    else if (clk_en)
    begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      rx_r <= rx_nxt;
      core_in_r <= core_in_nxt;
      pu_r <= pu_nxt;
      pdn_r <= pdn_nxt;
      fol_r <= fol_nxt;
      keep_r <= keep_nxt;
      hyst_r <= hyst_nxt;
      drive_r <= drive_nxt;
      clamp_r <= clamp_nxt;
    end
  end

  // scan capture: pin level, output value and enable per pin
  generate
    for (genvar g = 0; g < N; g++)
    begin : g_bs
      assign bs_cap[g*pkpc_pkg::BS_CELLS + pkpc_pkg::BS_IN_POS] = pin_sync_r[g];
      assign bs_cap[g*pkpc_pkg::BS_CELLS + pkpc_pkg::BS_OUT_POS] = out_r[g];
      assign bs_cap[g*pkpc_pkg::BS_CELLS + pkpc_pkg::BS_OE_POS] = oe_r[g];
    end
  endgenerate

  pkpc_bscan_chain #(
    .W(BW)
  ) u_bscan (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .cap_vec(bs_cap),
    .upd_vec(bs_upd),
    .bs_tdi(bs_tdi),
    .bs_capture(bs_capture),
    .bs_shift(bs_shift),
    .bs_update(bs_update),
    .bs_tdo(bs_tdo)
  );

  assign core_in = core_in_r;
  assign pad_out = out_r;
  assign pad_oe = oe_r;
  assign pad_pull_up = pu_r;
  assign pad_pull_down = pdn_r;
  assign pad_follow = fol_r;
  assign pad_keep_val = keep_r;
  assign pad_rx_en = rx_r;
  assign pad_clamp_en = clamp_r;
  assign pad_hyst = hyst_r;
  assign pad_drive = drive_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_init_pullup;
    clk_en && phase_r == pkpc_pkg::PH_CFG |=> pad_pull_up == '1 && pad_follow == '0;
  endproperty
  a_init_pullup: assert property (p_init_pullup) else $error("pull-up not active during init");

  property p_cfg_clamp;
    clk_en && phase_r == pkpc_pkg::PH_CFG |=> pad_clamp_en == '0;
  endproperty
  a_cfg_clamp: assert property (p_cfg_clamp) else $error("clamp enabled during configuration");

  property p_cfg_isolate;
    clk_en && phase_r == pkpc_pkg::PH_CFG && !bs_extest |=> pad_oe == '0 && pad_rx_en == '0 && core_in == '1;
  endproperty
  a_cfg_isolate: assert property (p_cfg_isolate) else $error("pad not isolated in configuration");

  property p_cfg_defaults;
    clk_en && phase_r == pkpc_pkg::PH_CFG |=> pad_hyst == '1 && pad_drive == {N{pkpc_pkg::DRIVE_4MA}};
  endproperty
  a_cfg_defaults: assert property (p_cfg_defaults) else $error("wrong unconfigured defaults");

  property p_unused_input;
    clk_en && phase_r == pkpc_pkg::PH_RUN && !bs_extest
      |=> (pad_oe & ~$past(pin_used)) == '0 && (pad_pull_up | $past(pin_used)) == '1;
  endproperty
  a_unused_input: assert property (p_unused_input) else $error("unused pad not a pulled-up input");

  property p_no_lp_without_allow;
    clk_en && phase_r == pkpc_pkg::PH_RUN && !pad_lowpower_allow |=> phase_r != pkpc_pkg::PH_PD;
  endproperty
  a_no_lp_without_allow: assert property (p_no_lp_without_allow) else $error("low power without permission");

  property p_pd_hiz;
    clk_en && phase_r == pkpc_pkg::PH_PD && !bs_extest |=> (pad_oe & $past(lp_en)) == '0;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("low-power pad driving in power-down");

  property p_pd_follow;
    clk_en && phase_r == pkpc_pkg::PH_PD
      |=> (pad_follow | ~$past(lp_en)) == '1 && ((pad_pull_up | pad_pull_down) & $past(lp_en)) == '0;
  endproperty
  a_pd_follow: assert property (p_pd_follow) else $error("keeper not follower in power-down");

  property p_pd_in_high;
    clk_en && phase_r == pkpc_pkg::PH_PD |=> (core_in | ~$past(lp_en & lp_in_force_hi)) == '1;
  endproperty
  a_pd_in_high: assert property (p_pd_in_high) else $error("input not forced high in power-down");

  property p_run_drive;
    clk_en && phase_r == pkpc_pkg::PH_RUN && !bs_extest
      |=> pad_oe == $past(core_oe & pin_used) && pad_out == $past(core_out);
  endproperty
  a_run_drive: assert property (p_run_drive) else $error("driver not following output enable");

  property p_pd_exit;
    clk_en && phase_r == pkpc_pkg::PH_PD && !pd_active && !cfg_busy |=> phase_r == pkpc_pkg::PH_RUN;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down overrides not released");

  property p_follow_hold;
    clk_en && (pad_rx_en | pad_oe) == '0 |=> $stable(pad_keep_val);
  endproperty
  a_follow_hold: assert property (p_follow_hold) else $error("follower value lost while floating");

  c_cfg_done: cover property (phase_r == pkpc_pkg::PH_CFG ##1 phase_r == pkpc_pkg::PH_RUN);
  c_pd_enter: cover property (phase_r == pkpc_pkg::PH_RUN ##1 phase_r == pkpc_pkg::PH_PD);
  c_pd_leave: cover property (phase_r == pkpc_pkg::PH_PD ##1 phase_r == pkpc_pkg::PH_RUN);

endmodule

//--- pkpc_pin_model.sv
// board-side model of the package pins: other drivers, keepers and floating lines
`timescale 1ns/100ps
module pkpc_pin_model #(
  parameter int N = 2
) (
  // clock
  input wire logic sys_clk,
  // pad cell side of the block
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pull_up,
  input wire logic [N-1:0] pad_pull_down,
  input wire logic [N-1:0] pad_follow,
  input wire logic [N-1:0] pad_keep_val,
  // external device on the line
  input wire logic [N-1:0] ext_oe,
  input wire logic [N-1:0] ext_val,
  // resolved pin level
  output logic [N-1:0] pad_in
);
  // a truly floating line wanders, so it toggles instead of keeping its value
  logic [N-1:0] float_r = '0;
  always_ff @(posedge sys_clk)
  begin
    float_r <= ~pad_in;
  end
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_oe[i])
        pad_in[i] = ext_val[i];
      else if (pad_pull_up[i])
        pad_in[i] = 1'b1;
      else if (pad_pull_down[i])
        pad_in[i] = 1'b0;
      else if (pad_follow[i])
        pad_in[i] = pad_keep_val[i];
      else
        pad_in[i] = float_r[i];
    end
  end
endmodule

//--- tb.sv
// self-checking testbench for the pad keeper and power-down control block
`timescale 1ns/100ps
module tb;
  localparam int N = 2;
  typedef struct {logic [N-1:0] used; logic [2*N-1:0] kc; logic [N-1:0] co, oe, up, dn, fl, eoe;} pkpc_row_t;
  pkpc_row_t rows [4] = '{'{2'b11, 4'h6, 2'b01, 2'b11, 2'b10, 2'b01, 2'b00, 2'b11},
                          '{2'b11, 4'h3, 2'b10, 2'b01, 2'b00, 2'b00, 2'b01, 2'b01},
                          '{2'b01, 4'he, 2'b11, 2'b11, 2'b10, 2'b01, 2'b00, 2'b01},
                          '{2'b00, 4'hf, 2'b11, 2'b11, 2'b11, 2'b00, 2'b00, 2'b00}};
  logic sys_clk = 0, arst_n = 0, clk_en = 1, cfg_busy = 1, pd_active = 0, pad_lowpower_allow = 0;
  logic [N-1:0] pin_used = '0, lp_en = 2'b01, lp_in_force_hi = 2'b01, hyst_cfg = '0, drive_cfg = '1;
  logic [N-1:0] clamp_cfg = '1, core_out = '0, core_oe = '0, ext_oe = '0, ext_val = '0;
  logic [2*N-1:0] keeper_cfg = '0;
  logic bs_tdi = 0, bs_capture = 0, bs_shift = 0, bs_update = 0, bs_extest = 0;
  logic [N-1:0] core_in, pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, pad_follow;
  logic [N-1:0] pad_keep_val, pad_rx_en, pad_clamp_en, pad_hyst, pad_drive;
  logic bs_tdo;
  int num_errors = 0;
  int checks_done = 0;
  logic [5:0] scan_exp = 6'b111100;
  logic [5:0] scan_pat = 6'b100110;

  pkpc_pad_ctrl #(.N(N)) u_pkpc_pad_ctrl (.sys_clk, .arst_n, .clk_en, .cfg_busy, .pd_active, .pad_lowpower_allow,
    .pin_used, .keeper_cfg, .lp_en, .lp_in_force_hi, .hyst_cfg, .drive_cfg, .clamp_cfg, .core_out, .core_oe,
    .core_in, .pad_in, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down, .pad_follow, .pad_keep_val, .pad_rx_en,
    .pad_clamp_en, .pad_hyst, .pad_drive, .bs_tdi, .bs_capture, .bs_shift, .bs_update, .bs_extest, .bs_tdo);
  pkpc_pin_model #(.N(N)) u_pkpc_pin_model (.sys_clk, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down,
    .pad_follow, .pad_keep_val, .ext_oe, .ext_val, .pad_in);

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cfg_check();
    chk(pad_pull_up, '1);
    chk(pad_clamp_en, '0);
    chk(pad_oe, '0);
    chk(pad_rx_en, '0);
    chk(core_in, '1);
    chk(pad_hyst, '1);
    chk(pad_drive, {N{pkpc_pkg::DRIVE_4MA}});
  endtask

  task automatic apply(input logic [N-1:0] u, input logic [2*N-1:0] k, input logic [N-1:0] co, oe);
    @(posedge sys_clk);
    pin_used <= u;
    keeper_cfg <= k;
    core_out <= co;
    core_oe <= oe;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic pd(input logic a, input logic p);
    @(posedge sys_clk);
    pad_lowpower_allow <= a;
    pd_active <= p;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic ext(input logic [N-1:0] oe, input logic [N-1:0] v);
    @(posedge sys_clk);
    ext_oe <= oe;
    ext_val <= v;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  initial
  begin
    repeat (2000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1;
    cfg_check();
    repeat (10) @(posedge sys_clk);
    arst_n <= 1;
    repeat (3) @(posedge sys_clk);
    #1;
    cfg_check();
    $display("test config done");
    @(posedge sys_clk);
    cfg_busy <= 0;
    foreach (rows[i])
    begin
      apply(rows[i].used, rows[i].kc, rows[i].co, rows[i].oe);
      chk(pad_pull_up, rows[i].up);
      chk(pad_pull_down, rows[i].dn);
      chk(pad_follow, rows[i].fl);
      chk(pad_oe, rows[i].eoe);
      chk(pad_out & pad_oe, rows[i].co & rows[i].eoe);
      chk(pad_rx_en, '1);
      chk(pad_clamp_en, clamp_cfg);
      chk(pad_hyst, hyst_cfg);
      chk(pad_drive, drive_cfg);
    end
    $display("test rows done");
    apply(2'b11, 4'h6, 2'b10, 2'b11);
    pd(1, 1);
    chk(pad_oe, 2'b10);
    chk(pad_follow, 2'b01);
    chk(pad_pull_up | pad_pull_down, 2'b10);
    chk(core_in, 2'b11);
    chk(pad_in, 2'b10);
    pd(1, 0);
    chk(pad_oe, 2'b11);
    chk(pad_pull_up, 2'b10);
    chk(pad_follow, 2'b00);
    chk(core_in, 2'b10);
    pd(0, 1);
    chk(pad_oe, 2'b11);
    chk(pad_follow, 2'b00);
    pd(0, 0);
    $display("test power-down done");
    apply(2'b11, 4'h3, 2'b00, 2'b00);
    ext(2'b01, 2'b01);
    chk(pad_keep_val & 2'b01, 2'b01);
    ext(2'b00, 2'b00);
    chk(pad_in & 2'b01, 2'b01);
    ext(2'b01, 2'b00);
    chk(pad_keep_val & 2'b01, 2'b00);
    ext(2'b00, 2'b00);
    $display("test follower done");
    // enable low must freeze every output although inputs move
    @(posedge sys_clk);
    clk_en <= 1'h0;
    core_oe <= 2'h3;
    keeper_cfg <= 4'h5;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(pad_oe, 2'h0);
    chk(pad_follow, 2'h1);
    // second reset in mid-run, taken from the running phase
    @(posedge sys_clk);
    clk_en <= 1'h1;
    arst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    cfg_check();
    @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(pad_oe, 2'h3);
    chk(pad_follow, 2'h0);
    chk(pad_rx_en, 2'h3);
    $display("test hold and reset done");
    apply(2'b11, 4'h6, 2'b10, 2'b11);
    @(posedge sys_clk);
    bs_capture <= 1;
    @(posedge sys_clk);
    bs_capture <= 0;
    bs_shift <= 1;
    bs_tdi <= scan_pat[0];
    for (int k = 0; k < 6; k++)
    begin
      #1;
      chk({1'b0, bs_tdo}, {1'b0, scan_exp[k]});
      @(posedge sys_clk);
      bs_tdi <= (k < 5) ? scan_pat[k+1] : 1'b0;
    end
    bs_shift <= 0;
    bs_update <= 1;
    @(posedge sys_clk);
    bs_update <= 0;
    bs_extest <= 1;
    cfg_busy <= 1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(pad_oe, 2'b11);
    chk(pad_out, 2'b01);
    @(posedge sys_clk);
    bs_extest <= 0;
    repeat (3) @(posedge sys_clk);
    #1;
    cfg_check();
    $display("test scan done");
    end_sim();
  end
endmodule
